// [bcm_pkg.sv]
// Purpose: Shared constants and types of the branch/call/move execution core
// Assumes: One clock; a machine cycle is two clocks (phase 0 and phase 1)
// Notes:   Opcodes are the instruction encodings; all else is block layout
package bcm_pkg;

  // Opcodes
  localparam logic [7:0] OP_BR_NC     = 8'h50;
  localparam logic [7:0] OP_BR_NZ     = 8'h70;
  localparam logic [7:0] OP_BR_Z      = 8'h60;
  localparam logic [7:0] OP_LONG_SUBROUTINE_CALL     = 8'h12;
  localparam logic [7:0] OP_LONG_UNCONDITIONAL_JUMP      = 8'h02;
  localparam logic [7:0] OP_MOV_A_DIR = 8'he5;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_MOV_DIR_A = 8'hf5;
  localparam logic [7:0] OP_MOV_C_BIT = 8'ha2;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_LOAD_PTR  = 8'h90;
  localparam logic [7:0] OP_CODE_PTR  = 8'h93;
  localparam logic [7:0] OP_CODE_PC   = 8'h83;
  localparam logic [7:0] OP_XRD_PTR   = 8'he0;
  localparam logic [7:0] OP_XWR_PTR   = 8'hf0;
  // Upper five bits of the register-select forms
  localparam logic [4:0] OP5_MOV_A_RN   = 5'h1d;
  localparam logic [4:0] OP5_MOV_RN_A   = 5'h1f;
  localparam logic [4:0] OP5_MOV_RN_IMM = 5'h0f;

  // Direct addresses with special handling
  localparam logic [7:0] ACC_DIR_ADDR  = 8'he0;
  localparam logic [7:0] HIGH_PORT_DIR = 8'ha0;

  // Reset values
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  SP_RESET     = 8'h07;
  localparam logic [7:0]  HI_SFR_RESET = 8'hff;

  // Fixed sizes
  localparam logic [15:0] LEN_BRANCH = 16'h0002;
  localparam logic [15:0] LEN_LONG   = 16'h0003;

  typedef enum logic [2:0] {
    ST_EXEC   = 3'b001,
    ST_SECOND = 3'b010,
    ST_HOLD   = 3'b100
  } bcm_state_e;

  typedef enum logic [2:0] {
    XS_IDLE = 3'b001,
    XS_ADDR = 3'b010,
    XS_DATA = 3'b100
  } bcm_xstep_e;

endpackage

// [bcm_xfer_if.sv]
// Purpose: Carrier between the execution core and the external port sequencer
// Assumes: Core holds addr, wdata and hi_sfr steady through a transfer
// Notes:   rdata is the low port input, valid while the read strobe is low
`timescale 1ns/1ps
interface bcm_xfer_if;
  logic        start;
  logic        write;
  logic        wide;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  hi_sfr;
  logic [7:0]  rdata;
  modport core (output start, write, wide, addr, wdata, hi_sfr, input rdata);
  modport port (input start, write, wide, addr, wdata, hi_sfr, output rdata);
endinterface

// [bcm_xport.sv]
// Purpose: External data move sequencer on the multiplexed low port
// Assumes: start is a one-clock pulse at phase 1 of the first machine cycle
// Notes:   Address phase one clock, strobe phase one clock
`timescale 1ns/1ps
module bcm_xport (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Core side
  bcm_xfer_if.port        x,
  // Pins
  input  wire logic [7:0] low_port_in,
  output logic      [7:0] low_port_out,
  output logic            low_port_oe_out,
  output logic      [7:0] high_port_out,
  output logic            ale_out,
  output logic            rd_n_out,
  output logic            wr_n_out
);

  typedef struct packed {
    bcm_pkg::bcm_xstep_e step;
    logic                write;
    logic                wide;
    logic                ale;
    logic                rd_n;
    logic                wr_n;
    logic [7:0]          lo;
    logic                lo_oe;
    logic [7:0]          hi;
  } bcm_xport_s;

  bcm_xport_s r;
  bcm_xport_s next_r;

  assign x.rdata = low_port_in;

  always_comb begin
    next_r     = r;
    next_r.ale = 1'b0;
    case (r.step)
      bcm_pkg::XS_IDLE: begin
        next_r.rd_n  = 1'b1;
        next_r.wr_n  = 1'b1;
        next_r.lo_oe = 1'b0;
        if (x.start) begin
          // Low address byte shares the port with data
          next_r.step  = bcm_pkg::XS_ADDR;
          next_r.ale   = 1'b1;
          next_r.write = x.write;
          next_r.wide  = x.wide;
          next_r.lo    = x.addr[7:0];
          next_r.lo_oe = 1'b1;
        end
      end
      bcm_pkg::XS_ADDR: begin
        // Exactly one byte moves per transfer
        next_r.step  = bcm_pkg::XS_DATA;
        next_r.rd_n  = r.write;
        next_r.wr_n  = ~r.write;
        next_r.lo    = x.wdata;
        next_r.lo_oe = r.write;
      end
      bcm_pkg::XS_DATA: begin
        next_r.step  = bcm_pkg::XS_IDLE;
        next_r.rd_n  = 1'b1;
        next_r.wr_n  = 1'b1;
        next_r.lo_oe = 1'b0;
      end
      default: begin
        next_r.step = bcm_pkg::XS_IDLE;
      end
    endcase
    // Pointer high byte on the pins, latch value elsewhere
    if (next_r.step != bcm_pkg::XS_IDLE && next_r.wide) begin
      next_r.hi = x.addr[15:8];
    end else begin
      next_r.hi = x.hi_sfr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '{step: bcm_pkg::XS_IDLE, write: 1'b0, wide: 1'b0, ale: 1'b0,
             rd_n: 1'b1, wr_n: 1'b1, lo: 8'h00, lo_oe: 1'b0,
             hi: bcm_pkg::HI_SFR_RESET};
    end else begin
      r <= next_r;
    end
  end

  assign low_port_out    = r.lo;
  assign low_port_oe_out = r.lo_oe;
  assign high_port_out   = r.hi;
  assign ale_out         = r.ale;
  assign rd_n_out        = r.rd_n;
  assign wr_n_out        = r.wr_n;

endmodule

// [bcm_core.sv]
// Purpose: Execution core for branches, long call/jump, moves, table and external reads
// Assumes: code_data_in holds the three bytes at code_addr_out, same clock
// Notes:   Machine cycle is two clocks; phase 0 latches, phase 1 executes
`timescale 1ns/1ps
module bcm_core (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Program memory window
  output logic      [15:0] code_addr_out,
  input  wire logic [23:0] code_data_in,
  // Direct byte space
  output logic      [7:0]  dir_addr_out,
  input  wire logic [7:0]  dir_rdata_in,
  output logic             dir_we_out,
  output logic      [7:0]  dir_wdata_out,
  // Bit space
  output logic      [7:0]  bit_addr_out,
  input  wire logic        bit_rdata_in,
  output logic             bit_we_out,
  output logic             bit_wdata_out,
  // Stack writes
  output logic             stk_we_out,
  output logic      [7:0]  stk_addr_out,
  output logic      [7:0]  stk_wdata_out,
  // External data pins
  input  wire logic [7:0]  low_port_in,
  output logic      [7:0]  low_port_out,
  output logic             low_port_oe_out,
  output logic      [7:0]  high_port_out,
  output logic             ale_out,
  output logic             rd_n_out,
  output logic             wr_n_out,
  // State view
  output logic      [15:0] pc_out,
  output logic      [7:0]  acc_out,
  output logic             carry_out,
  output logic      [7:0]  sp_out,
  output logic      [15:0] pointer16_out,
  output logic             illegal_out
);

  typedef struct packed {
    logic                ph;
    bcm_pkg::bcm_state_e st;
    logic [15:0]         pc;
    logic [7:0]          acc;
    logic                cy;
    logic [7:0]          sp;
    logic [15:0]         ptr;
    logic [7:0][7:0]     regs;
    logic [7:0]          hi_sfr;
    logic [7:0]          op;
    logic [7:0]          b2;
    logic [7:0]          b3;
    logic [15:0]         code_addr;
    logic [7:0]          dir_addr;
    logic                dir_we;
    logic [7:0]          dir_wdata;
    logic                bit_we;
    logic                bit_wdata;
    logic                stk_we;
    logic [7:0]          stk_addr;
    logic [7:0]          stk_wdata;
    logic                xs;
    logic                xw;
    logic                xwide;
    logic [15:0]         xaddr;
    logic [7:0]          xwdata;
    logic                illegal;
  } bcm_core_s;

  bcm_core_s   r;
  bcm_core_s   next_r;
  bcm_xfer_if  xf ();

  logic [15:0] rel16;
  logic [15:0] ret16;
  logic [15:0] acc16;
  logic [7:0]  rn_val;
  logic [7:0]  c_op;
  logic        c_external_data_move;
  logic        taken;

  assign rel16  = {{8{r.b2[7]}}, r.b2};
  assign ret16  = r.pc + bcm_pkg::LEN_LONG;
  assign acc16  = {8'h00, r.acc};
  assign rn_val = r.regs[r.op[2:0]];
  assign c_op   = code_data_in[7:0];
  assign c_external_data_move = (c_op[7:5] == 3'b111) && (c_op[3:2] == 2'b00) && (c_op[1:0] != 2'b01);
  assign taken  = (r.op == bcm_pkg::OP_BR_NC) ? ~r.cy :
                  (r.op == bcm_pkg::OP_BR_NZ) ? (r.acc != 8'h00) :
                  (r.acc == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r         = r;
    next_r.ph      = ~r.ph;
    next_r.dir_we  = 1'b0;
    next_r.bit_we  = 1'b0;
    next_r.stk_we  = 1'b0;
    next_r.xs      = 1'b0;
    next_r.illegal = 1'b0;
    if (!r.ph) begin
      if (r.st == bcm_pkg::ST_EXEC) begin
        // Latch the window so the direct and bit reads settle by phase 1
        next_r.op       = c_op;
        next_r.b2       = code_data_in[15:8];
        next_r.b3       = code_data_in[23:16];
        next_r.dir_addr = code_data_in[15:8];
        if (c_external_data_move) begin
          // Start early so both bus phases fit in two machine cycles
          next_r.xs     = 1'b1;
          next_r.xw     = c_op[4];
          next_r.xwide  = ~c_op[1];
          next_r.xwdata = r.acc;
          if (!c_op[1]) begin
            next_r.xaddr = r.ptr;
          end else begin
            next_r.xaddr = {r.hi_sfr, r.regs[c_op[0]]};
          end
        end
      end
    end else begin
      case (r.st)
        bcm_pkg::ST_EXEC: begin
          next_r.pc = r.pc + 16'h0001;
          if (r.op == bcm_pkg::OP_BR_NC || r.op == bcm_pkg::OP_BR_NZ ||
              r.op == bcm_pkg::OP_BR_Z) begin
            next_r.pc = r.pc + bcm_pkg::LEN_BRANCH;
            next_r.st = bcm_pkg::ST_SECOND;
          end else if (r.op == bcm_pkg::OP_LONG_SUBROUTINE_CALL) begin
            next_r.pc        = ret16;
            next_r.sp        = r.sp + 8'h01;
            next_r.stk_we    = 1'b1;
            next_r.stk_addr  = r.sp + 8'h01;
            next_r.stk_wdata = ret16[7:0];
            next_r.st        = bcm_pkg::ST_SECOND;
          end else if (r.op == bcm_pkg::OP_LONG_UNCONDITIONAL_JUMP || r.op == bcm_pkg::OP_LOAD_PTR) begin
            next_r.pc = ret16;
            next_r.st = bcm_pkg::ST_SECOND;
          end else if (r.op[7:3] == bcm_pkg::OP5_MOV_A_RN) begin
            next_r.acc = rn_val;
          end else if (r.op[7:3] == bcm_pkg::OP5_MOV_RN_A) begin
            next_r.regs[r.op[2:0]] = r.acc;
          end else if (r.op[7:3] == bcm_pkg::OP5_MOV_RN_IMM) begin
            next_r.pc              = r.pc + bcm_pkg::LEN_BRANCH;
            next_r.regs[r.op[2:0]] = r.b2;
          end else if (r.op == bcm_pkg::OP_MOV_A_IMM) begin
            next_r.pc  = r.pc + bcm_pkg::LEN_BRANCH;
            next_r.acc = r.b2;
          end else if (r.op == bcm_pkg::OP_MOV_A_DIR) begin
            next_r.pc = r.pc + bcm_pkg::LEN_BRANCH;
            if (r.b2 == bcm_pkg::ACC_DIR_ADDR) begin
              // Invalid form: flagged, accumulator left alone
              next_r.illegal = 1'b1;
            end else if (r.b2 == bcm_pkg::HIGH_PORT_DIR) begin
              next_r.acc = r.hi_sfr;
            end else begin
              next_r.acc = dir_rdata_in;
            end
          end else if (r.op == bcm_pkg::OP_MOV_DIR_A) begin
            next_r.pc = r.pc + bcm_pkg::LEN_BRANCH;
            if (r.b2 == bcm_pkg::HIGH_PORT_DIR) begin
              next_r.hi_sfr = r.acc;
            end else if (r.b2 != bcm_pkg::ACC_DIR_ADDR) begin
              next_r.dir_we    = 1'b1;
              next_r.dir_wdata = r.acc;
            end
          end else if (r.op == bcm_pkg::OP_MOV_C_BIT) begin
            next_r.pc = r.pc + bcm_pkg::LEN_BRANCH;
            next_r.cy = bit_rdata_in;
          end else if (r.op == bcm_pkg::OP_MOV_BIT_C) begin
            next_r.pc = r.pc + bcm_pkg::LEN_BRANCH;
            next_r.st = bcm_pkg::ST_SECOND;
          end else if (r.op == bcm_pkg::OP_CODE_PTR) begin
            next_r.code_addr = r.ptr + acc16;
            next_r.st        = bcm_pkg::ST_SECOND;
          end else if (r.op == bcm_pkg::OP_CODE_PC) begin
            next_r.code_addr = r.pc + 16'h0001 + acc16;
            next_r.st        = bcm_pkg::ST_SECOND;
          end else if ((r.op[7:5] == 3'b111) && (r.op[3:2] == 2'b00) &&
                       (r.op[1:0] != 2'b01)) begin
            next_r.st = bcm_pkg::ST_SECOND;
          end else begin
            next_r.illegal = 1'b1;
          end
        end
        bcm_pkg::ST_SECOND: begin
          next_r.st = bcm_pkg::ST_EXEC;
          if (r.op == bcm_pkg::OP_LONG_SUBROUTINE_CALL) begin
            next_r.sp        = r.sp + 8'h01;
            next_r.stk_we    = 1'b1;
            next_r.stk_addr  = r.sp + 8'h01;
            next_r.stk_wdata = r.pc[15:8];
            next_r.pc        = {r.b2, r.b3};
          end else if (r.op == bcm_pkg::OP_LONG_UNCONDITIONAL_JUMP) begin
            next_r.pc = {r.b2, r.b3};
          end else if (r.op == bcm_pkg::OP_LOAD_PTR) begin
            next_r.ptr = {r.b2, r.b3};
          end else if (r.op == bcm_pkg::OP_MOV_BIT_C) begin
            next_r.bit_we    = 1'b1;
            next_r.bit_wdata = r.cy;
          end else if (r.op == bcm_pkg::OP_CODE_PTR || r.op == bcm_pkg::OP_CODE_PC) begin
            next_r.acc = code_data_in[7:0];
          end else if (r.op[7:4] == 4'he) begin
            next_r.acc = xf.rdata;
          end else if (taken) begin
            next_r.pc = r.pc + rel16;
          end
        end
        default: begin
          next_r.st = bcm_pkg::ST_EXEC;
        end
      endcase
      if (next_r.st == bcm_pkg::ST_EXEC) begin
        next_r.code_addr = next_r.pc;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r           <= '0;
      r.st        <= bcm_pkg::ST_EXEC;
      r.pc        <= bcm_pkg::PC_RESET;
      r.code_addr <= bcm_pkg::PC_RESET;
      r.sp        <= bcm_pkg::SP_RESET;
      r.hi_sfr    <= bcm_pkg::HI_SFR_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign xf.start  = r.xs;
  assign xf.write  = r.xw;
  assign xf.wide   = r.xwide;
  assign xf.addr   = r.xaddr;
  assign xf.wdata  = r.xwdata;
  assign xf.hi_sfr = r.hi_sfr;

  bcm_xport u_xport (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .x               (xf.port),
    .low_port_in     (low_port_in),
    .low_port_out    (low_port_out),
    .low_port_oe_out (low_port_oe_out),
    .high_port_out   (high_port_out),
    .ale_out         (ale_out),
    .rd_n_out        (rd_n_out),
    .wr_n_out        (wr_n_out)
  );

  assign code_addr_out = r.code_addr;
  assign dir_addr_out  = r.dir_addr;
  assign dir_we_out    = r.dir_we;
  assign dir_wdata_out = r.dir_wdata;
  assign bit_addr_out  = r.dir_addr;
  assign bit_we_out    = r.bit_we;
  assign bit_wdata_out = r.bit_wdata;
  assign stk_we_out    = r.stk_we;
  assign stk_addr_out  = r.stk_addr;
  assign stk_wdata_out = r.stk_wdata;
  assign pc_out        = r.pc;
  assign acc_out       = r.acc;
  assign carry_out     = r.cy;
  assign sp_out        = r.sp;
  assign pointer16_out = r.ptr;
  assign illegal_out   = r.illegal;

  ////////////////////////////////////////////////////////////////////////////
  logic ex1;
  assign ex1 = r.ph && (r.st == bcm_pkg::ST_EXEC);

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_br_nc;
    ex1 && r.op == bcm_pkg::OP_BR_NC |-> ##3 (r.cy == $past(r.cy, 3)) &&
      (r.pc == ($past(r.cy, 3) ? $past(r.pc, 3) + 16'h0002
                               : $past(r.pc, 3) + 16'h0002 + $past(rel16, 3)));
  endproperty
  a_br_nc: assert property (p_br_nc) else $error("carry-clear branch wrong");
  property p_br_nz;
    ex1 && r.op == bcm_pkg::OP_BR_NZ && r.acc != 8'h00
      |-> ##3 r.pc == $past(r.pc, 3) + 16'h0002 + $past(rel16, 3);
  endproperty
  a_br_nz: assert property (p_br_nz) else $error("nonzero branch not taken");
  property p_br_z;
    ex1 && r.op == bcm_pkg::OP_BR_Z && r.acc != 8'h00
      |=> r.st == bcm_pkg::ST_SECOND ##2 (r.pc == $past(r.pc, 3) + 16'h0002)
          && $stable(r.acc);
  endproperty
  a_br_z: assert property (p_br_z) else $error("zero branch fell wrong");
  property p_call_push;
    ex1 && r.op == bcm_pkg::OP_LONG_SUBROUTINE_CALL |=> r.stk_we && r.stk_addr == $past(r.sp) + 8'h01
      && r.stk_wdata == $past(ret16[7:0]) ##2 r.stk_we && r.stk_wdata == $past(ret16[15:8], 3);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push order wrong");
  property p_call_dest;
    ex1 && r.op == bcm_pkg::OP_LONG_SUBROUTINE_CALL
      |-> ##3 r.sp == $past(r.sp, 3) + 8'h02 && r.pc == {$past(r.b2, 3), $past(r.b3, 3)};
  endproperty
  a_call_dest: assert property (p_call_dest) else $error("call target wrong");
  property p_jmp;
    ex1 && r.op == bcm_pkg::OP_LONG_UNCONDITIONAL_JUMP |-> ##3 r.pc == {$past(r.b2, 3), $past(r.b3, 3)};
  endproperty
  a_jmp: assert property (p_jmp) else $error("long jump target wrong");
  property p_mov_rn;
    ex1 && r.op[7:3] == bcm_pkg::OP5_MOV_A_RN
      |=> r.acc == $past(rn_val) && r.pc == $past(r.pc) + 16'h0001;
  endproperty
  a_mov_rn: assert property (p_mov_rn) else $error("register move wrong");
  property p_bit;
    ex1 && r.op == bcm_pkg::OP_MOV_C_BIT |=> r.cy == $past(bit_rdata_in)
      && r.st == bcm_pkg::ST_EXEC;
  endproperty
  a_bit: assert property (p_bit) else $error("bit to carry wrong");
  property p_ptr;
    ex1 && r.op == bcm_pkg::OP_LOAD_PTR |-> ##3 r.ptr == {$past(r.b2, 3), $past(r.b3, 3)};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load wrong");
  property p_code_ptr;
    ex1 && r.op == bcm_pkg::OP_CODE_PTR |=> r.code_addr == $past(r.ptr) + $past(acc16)
      ##2 r.ptr == $past(r.ptr, 3);
  endproperty
  a_code_ptr: assert property (p_code_ptr) else $error("table read address wrong");
  property p_hi_port;
    r.xs && r.xwide |-> ##2 high_port_out == r.xaddr[15:8] && r.hi_sfr == $past(r.hi_sfr, 2);
  endproperty
  a_hi_port: assert property (p_hi_port) else $error("high port wrong in access");
  property p_xrd;
    ex1 && r.op == bcm_pkg::OP_XRD_PTR |-> ##3 r.acc == $past(low_port_in);
  endproperty
  a_xrd: assert property (p_xrd) else $error("external read byte wrong");

  c_call: cover property (ex1 && r.op == bcm_pkg::OP_LONG_SUBROUTINE_CALL);
  c_taken: cover property (r.ph && r.st == bcm_pkg::ST_SECOND && taken &&
                           r.op == bcm_pkg::OP_BR_NC);
  c_xwr: cover property (ex1 && r.op == bcm_pkg::OP_XWR_PTR);

endmodule

// [bcm_xram.sv]
// Purpose: External data RAM model on the multiplexed port
// Assumes: Address latched while ale is high
// Notes:   No pull-up, so an idle bus shows its last level inverted
`timescale 1ns/1ps
module bcm_xram (
  // Pins
  input  wire logic       clk_in,
  input  wire logic       ale_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] lo_in,
  input  wire logic [7:0] hi_in,
  output logic      [7:0] lo_out
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic [7:0]  last = 8'h00;
  //////////////////////////////
  always @(posedge clk_in) begin
    last <= lo_out;
    if (ale_in) addr <= {hi_in, lo_in};
    if (!wr_n_in) mem[addr] <= lo_in;
  end
  assign lo_out = oe_in ? lo_in : (!rd_n_in ? mem[addr] : ~last);
endmodule

// [bcm_core_tb.sv]
// Purpose: Self-checking bench for the execution core
// Assumes: Instructions run back to back, two clocks a machine cycle
// Notes:   Bytes are placed at the expected pc just before each fetch
`timescale 1ns/1ps
module bcm_core_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        bit_rd = 1'b0;
  logic        ill_seen = 1'b0;
  logic [7:0]  dir_rd = 8'h00;
  logic [7:0]  cmem [0:65535];
  logic [7:0]  stk [0:255];
  logic [15:0] caddr, pc, p16, ptr, pc_e, tgt;
  logic [7:0]  lo_i, lo_o, hi, acc, sp, a, rel, d, hi_seen, stk_a, stk_d;
  logic        oe, ale, rd_n, wr_n, cy, ill, stk_we, tk;
  logic [7:0]  dir_a, dir_wd, bit_a;
  logic        dir_we, bit_we, bit_wd;
  logic [7:0]  bop [3] = '{bcm_pkg::OP_BR_NZ, bcm_pkg::OP_BR_Z, bcm_pkg::OP_BR_NC};
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;
  //////////////////////////////
  bcm_core u_bcm_core (.clk_in(clk_in), .rst_in(rst_in), .code_addr_out(caddr),
    .code_data_in({cmem[16'(caddr + 16'h2)], cmem[16'(caddr + 16'h1)], cmem[caddr]}),
    .dir_addr_out(dir_a), .dir_rdata_in(dir_rd), .dir_we_out(dir_we), .dir_wdata_out(dir_wd),
    .bit_addr_out(bit_a), .bit_rdata_in(bit_rd), .bit_we_out(bit_we), .bit_wdata_out(bit_wd),
    .stk_we_out(stk_we), .stk_addr_out(stk_a), .stk_wdata_out(stk_d),
    .low_port_in(lo_i), .low_port_out(lo_o), .low_port_oe_out(oe),
    .high_port_out(hi), .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .pc_out(pc), .acc_out(acc), .carry_out(cy), .sp_out(sp),
    .pointer16_out(p16), .illegal_out(ill));
  bcm_xram u_bcm_xram (.clk_in(clk_in), .ale_in(ale), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .oe_in(oe), .lo_in(lo_o), .hi_in(hi), .lo_out(lo_i));
  //////////////////////////////
  initial forever #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (stk_we) stk[stk_a] <= stk_d;
    if (ale) hi_seen <= hi;
    if (ill) ill_seen <= 1'b1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Waits the documented cycle count, so a slow design shows as a pc mismatch
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                     input int n);
    {cmem[pc_e + 2], cmem[pc_e + 1], cmem[pc_e]} = {b2, b1, op};
    repeat (2 * n) @(negedge clk_in);
  endtask
  task automatic lda(input logic [7:0] v);
    run(bcm_pkg::OP_MOV_A_IMM, v, 8'h00, 1);
    pc_e = pc_e + 16'h2;
  endtask
  function automatic logic [15:0] br(input logic [15:0] p, input logic [7:0] r, input logic t);
    return t ? 16'(p + 16'h2 + {{8{r[7]}}, r}) : 16'(p + 16'h2);
  endfunction
  //////////////////////////////
  initial begin
    foreach (cmem[i]) cmem[i] = 8'h00;
    void'($urandom(32'h4af2));
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    pc_e = 16'h0000;
    tgt = 16'h2000;
    run(bcm_pkg::OP_LONG_UNCONDITIONAL_JUMP, tgt[15:8], tgt[7:0], 2);
    pc_e = tgt;
    chk("pc", pc, pc_e);
    ptr = {2'b01, 14'($urandom)};
    run(bcm_pkg::OP_LOAD_PTR, ptr[15:8], ptr[7:0], 2);
    pc_e = pc_e + 16'h3;
    chk("pointer", p16, ptr);
    $display("done jump");
    for (int i = 0; i < 12; i++) begin
      a = (i < 6) ? 8'h00 : 8'($urandom);
      rel = 8'($urandom);
      bit_rd = 1'($urandom);
      lda(a);
      run(bcm_pkg::OP_MOV_C_BIT, 8'h21, 8'h00, 1);
      pc_e = pc_e + 16'h2;
      chk("carry", cy, bit_rd);
      tk = (i % 3 == 0) ? (a != 8'h00) : (i % 3 == 1) ? (a == 8'h00) : !bit_rd;
      run(bop[i % 3], rel, 8'h00, 2);
      pc_e = br(pc_e, rel, tk);
      chk("pc", pc, pc_e);
      chk("acc", acc, a);
      chk("carry", cy, bit_rd);
    end
    $display("done branch");
    tgt = {4'h3, 12'($urandom)};
    run(bcm_pkg::OP_LONG_SUBROUTINE_CALL, tgt[15:8], tgt[7:0], 2);
    pc_e = pc_e + 16'h3;
    chk("sp", sp, bcm_pkg::SP_RESET + 8'h2);
    chk("push lo", stk[bcm_pkg::SP_RESET + 8'h1], pc_e[7:0]);
    // Second push pulse still stands here; the stack copy catches it one edge later
    chk("push addr", {stk_we, stk_a}, {1'b1, bcm_pkg::SP_RESET + 8'h2});
    chk("push hi", stk_d, pc_e[15:8]);
    pc_e = tgt;
    chk("pc", pc, pc_e);
    $display("done call");
    for (int i = 0; i < 2; i++) begin
      a = 8'($urandom) | 8'h02;
      d = 8'($urandom);
      lda(a);
      if (i == 0) cmem[ptr + a] = d;
      else cmem[pc_e + 16'h1 + a] = d;
      run(i == 0 ? bcm_pkg::OP_CODE_PTR : bcm_pkg::OP_CODE_PC, 8'h00, 8'h00, 2);
      pc_e = pc_e + 16'h1;
      chk("table", acc, d);
      chk("pointer", p16, ptr);
      chk("pc", pc, pc_e);
    end
    $display("done table");
    a = 8'($urandom);
    lda(a);
    run(bcm_pkg::OP_XWR_PTR, 8'h00, 8'h00, 2);
    chk("xram", u_bcm_xram.mem[ptr], a);
    chk("high addr", hi_seen, ptr[15:8]);
    chk("high latch", hi, bcm_pkg::HI_SFR_RESET);
    pc_e = pc_e + 16'h1;
    lda(~a);
    run(bcm_pkg::OP_XRD_PTR, 8'h00, 8'h00, 2);
    pc_e = pc_e + 16'h1;
    chk("xread", acc, a);
    d = 8'($urandom);
    run({bcm_pkg::OP5_MOV_RN_IMM, 3'd0}, d, 8'h00, 1);
    pc_e = pc_e + 16'h2;
    run(8'hf2, 8'h00, 8'h00, 2);
    pc_e = pc_e + 16'h1;
    chk("xram", u_bcm_xram.mem[{bcm_pkg::HI_SFR_RESET, d}], a);
    run({bcm_pkg::OP5_MOV_A_RN, 3'd0}, 8'h00, 8'h00, 1);
    pc_e = pc_e + 16'h1;
    chk("acc", acc, d);
    run(8'he2, 8'h00, 8'h00, 2);
    pc_e = pc_e + 16'h1;
    chk("xread", acc, a);
    $display("done external");
    dir_rd = 8'($urandom);
    run(bcm_pkg::OP_MOV_A_DIR, 8'h30, 8'h00, 1);
    chk("acc", acc, dir_rd);
    chk("illegal", ill_seen, 1'b0);
    pc_e = pc_e + 16'h2;
    run(bcm_pkg::OP_MOV_A_DIR, bcm_pkg::ACC_DIR_ADDR, 8'h00, 1);
    chk("illegal", ill, 1'b1);
    chk("acc", acc, dir_rd);
    pc_e = pc_e + 16'h2;
    run(bcm_pkg::OP_MOV_DIR_A, 8'h30, 8'h00, 1);
    chk("dir write", {dir_we, dir_a, dir_wd}, {1'b1, 8'h30, dir_rd});
    pc_e = pc_e + 16'h2;
    run(bcm_pkg::OP_MOV_BIT_C, 8'h21, 8'h00, 2);
    chk("bit write", {bit_we, bit_a, bit_wd}, {1'b1, 8'h21, bit_rd});
    pc_e = pc_e + 16'h2;
    chk("pc", pc, pc_e);
    $display("done moves");
    complete_run();
  end
endmodule
